// ### pkg/sss_consts.svh
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH
// Configuration word indices (byte address = index * 4)
`define SSS_CFG_WORDS 5'd25
`define SSS_CFG_LAST 5'd24
`define SSS_CFG_DELAY 5'd8
`define SSS_CFG_THR 5'd16
`define SSS_CFG_MISC 5'd22
`define SSS_CFG_WDT 5'd23
`define SSS_CFG_END 12'h064
// Other register byte addresses
`define SSS_ADDR_CTRL 12'h080
`define SSS_ADDR_STAT 12'h084
`define SSS_ADDR_IRQ 12'h088
`define SSS_ADDR_MASK 12'h08c
`define SSS_ADDR_ADC 7'h05
`define SSS_ADDR_USER 3'h4
`define SSS_USER_WORDS 128
// Control and misc fields
`define SSS_CTRL_SAVE 0
`define SSS_CTRL_REBOOT 1
`define SSS_MISC_FORCE 4
`define SSS_MISC_MR_HIGH 5
`define SSS_MISC_MG_HIGH 6
// Reset values
`define SSS_RST_OUT 32'h0000003f
`define SSS_RST_MISC 32'h0000004f
// Timing
`define SSS_CLK_NS 8
`define SSS_TICK_NS 1000
`define SSS_TICK_CYC ((`SSS_TICK_NS + `SSS_CLK_NS - 1) / `SSS_CLK_NS)
`define SSS_MS_TICKS 1000
`endif

// ### pkg/sss_pkg.sv
package sss_pkg;
  typedef struct packed {
    logic [3:0] spare;
    logic margin_level;
    logic active_high;
    logic [25:0] term;
  } sss_out_t;
  typedef struct packed {
    logic [9:0] spare;
    logic window;
    logic range_hi;
    logic [9:0] thr_b;
    logic [9:0] thr_a;
  } sss_thr_t;
  typedef struct packed {
    logic [15:0] startup;
    logic [15:0] timeout;
  } sss_wdt_t;
  typedef enum logic [1:0] {NV_IDLE, NV_SAVE, NV_LOAD} sss_nv_t;
  typedef enum logic [1:0] {WD_HOLD, WD_START, WD_RUN} sss_wd_t;
  typedef enum logic {AD_START, AD_WAIT} sss_adc_t;
endpackage

// ### verilog/sss_top.sv
// Functional notes
// - Logic array lets any mix of six detectors and four inputs assert any output.
// - An output's term may include other outputs' states, alone or mixed.
// - Each output has its own release delay, kept in configuration storage.
// - Outputs and digital inputs each have selectable active level.
// - Manual reset drives every output to its asserted state.
// - Margin may freeze all outputs at their values when margining began.
// - Margin may instead force each output to a stored preset state.
// - Two independent watchdogs, each with timeout and startup delay settings.
// - After reset ends, watchdog first waits its startup delay, then normal timeout.
// - Host writes to configuration registers act at once, no reboot needed.
// - Host command copies current configuration into nonvolatile storage.
// - Every reboot, soft or hardware, loads configuration from nonvolatile storage.
// - Converter steps through eight inputs, storing each 10-bit result separately.
// - Host can read stored conversion results at any time.
// - Each input has two thresholds: two undervoltage, or window mode.
// - Host programs threshold codes; device keeps them in configuration storage.
// - Separate 4kb user storage area, host readable and writable.
`timescale 1ns/10ps
`default_nettype none
`include "sss_consts.svh"
module sss_top import sss_pkg::*; #(
  parameter int TICK_CYC = `SSS_TICK_CYC,
  parameter int MS_TICKS = `SSS_MS_TICKS,
  parameter int USER_WORDS = `SSS_USER_WORDS
) (
  input wire logic hclk, // 125 MHz clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  input wire logic [5:0] mon_above_a, // Comparator: above threshold A
  input wire logic [5:0] mon_above_b, // Comparator: above threshold B
  input wire logic [3:0] general_purpose_inputs, // Digital inputs
  input wire logic manual_reset_in, // Manual reset pin
  input wire logic margin_in, // Margin pin
  input wire logic [1:0] wdt_kick, // Watchdog inputs
  output sss_thr_t [5:0] thr_cfg, // Threshold settings to comparators
  output logic [2:0] adc_channel, // Converter channel select
  output logic adc_start, // Converter start pulse
  input wire logic adc_done, // Converter result valid
  input wire logic [9:0] adc_data, // Converter result
  input wire logic nv_erase, // Clears stored-configuration valid flag
  output logic [7:0] sequenced_outputs, // Output pins
  output logic irq // Interrupt, active high
);
  logic [19:0] s1, s2, s3, filt, raw;
  logic [1:0] kick_q, kick;
  logic [6:0] tick_cnt;
  logic [9:0] ms_cnt;
  logic tick_us, tick_ms;
  logic [31:0] cfg [25];
  logic [31:0] nv_mem [25];
  logic [31:0] nv_rd;
  logic nv_valid, nv_done;
  sss_nv_t nv_st;
  logic [4:0] nv_idx;
  logic [31:0] user_mem [USER_WORDS];
  logic [9:0] adc_res [8];
  sss_adc_t ad_st;
  logic adc_sweep;
  sss_out_t oc [8];
  logic [7:0] act_vec, preset_vec, pla_hit, eng, out_state;
  logic [15:0] dcnt [8];
  logic [25:0] src;
  logic [5:0] flt_a, flt_b;
  logic [3:0] gpi;
  logic mr, margin, mr_q, margin_q, force_mode;
  sss_wd_t wd_ph [2];
  logic [15:0] wd_cnt [2];
  logic [1:0] wd_exp, wd_ev;
  logic rst_cond;
  logic acc, wr_pend;
  logic [11:0] wr_addr;
  logic [31:0] rd_data;
  logic [5:0] irq_stat, irq_mask, ev;

  function automatic logic is_cfg(input logic [11:0] a);
    is_cfg = a < `SSS_CFG_END;
  endfunction
  function automatic logic is_user(input logic [11:0] a);
    is_user = a[11:9] == `SSS_ADDR_USER;
  endfunction
  function automatic logic is_adc(input logic [11:0] a);
    is_adc = a[11:5] == `SSS_ADDR_ADC;
  endfunction
  function automatic logic [31:0] cfg_default(input logic [4:0] i);
    if (i < `SSS_CFG_DELAY) begin
      cfg_default = `SSS_RST_OUT;
    end else if (i == `SSS_CFG_MISC) begin
      cfg_default = `SSS_RST_MISC;
    end else begin
      cfg_default = 32'h0;
    end
  endfunction

  // Pin inputs: a change counts once the second and third stages agree
  assign raw = {wdt_kick, margin_in, manual_reset_in, general_purpose_inputs, mon_above_b, mon_above_a};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
      kick_q <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      filt <= (s2 & s3) | (filt & (s2 | s3));
      kick_q <= filt[19:18];
    end
  end
  assign kick = filt[19:18] & ~kick_q;

  assign gpi = ~(filt[15:12] ^ cfg[`SSS_CFG_MISC][3:0]);
  assign mr = ~(filt[16] ^ cfg[`SSS_CFG_MISC][`SSS_MISC_MR_HIGH]);
  assign margin = ~(filt[17] ^ cfg[`SSS_CFG_MISC][`SSS_MISC_MG_HIGH]);
  assign force_mode = cfg[`SSS_CFG_MISC][`SSS_MISC_FORCE];

  // Sources: [5:0] fault A, [11:6] fault B, [15:12] inputs, [23:16] outputs, [25:24] watchdogs
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      thr_cfg[k] = sss_thr_t'(cfg[`SSS_CFG_THR + 5'(k)]);
      flt_a[k] = ~filt[k];
      // window mode turns B into an overvoltage detect
      flt_b[k] = thr_cfg[k].window ? filt[6 + k] : ~filt[6 + k];
    end
  end
  assign src = {wd_exp, out_state, gpi, flt_b, flt_a};

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      oc[i] = sss_out_t'(cfg[i]);
      act_vec[i] = oc[i].active_high;
      preset_vec[i] = oc[i].margin_level;
      // any selected source asserts the output
      pla_hit[i] = |(oc[i].term & src);
    end
  end

  // Time base; one divider feeds every slow count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= '0;
      ms_cnt <= '0;
    end else if (tick_cnt == 7'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
      ms_cnt <= (ms_cnt == 10'(MS_TICKS - 1)) ? 10'h0 : ms_cnt + 10'h1;
    end else begin
      tick_cnt <= tick_cnt + 7'h1;
    end
  end
  assign tick_us = tick_cnt == 7'(TICK_CYC - 1);
  assign tick_ms = tick_us && ms_cnt == 10'(MS_TICKS - 1);

  // assert at once, release after the output's delay in microseconds
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng <= '1;
      for (int i = 0; i < 8; i++) begin
        dcnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pla_hit[i]) begin
          eng[i] <= 1'b1;
          dcnt[i] <= '0;
        end else if (eng[i]) begin
          if (dcnt[i] >= cfg[`SSS_CFG_DELAY + 5'(i)][15:0]) begin
            eng[i] <= 1'b0;
          end else if (tick_us) begin
            dcnt[i] <= dcnt[i] + 16'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_state <= '1;
    end else if (mr) begin
      out_state <= '1;
    end else if (margin) begin
      out_state <= force_mode ? preset_vec : out_state;
    end else begin
      out_state <= eng;
    end
  end

  // output polarity applied at the pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sequenced_outputs <= '0;
    end else begin
      sequenced_outputs <= ~(out_state ^ act_vec);
    end
  end

  // two watchdogs; the first output counts as the system reset
  assign rst_cond = mr | out_state[0];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int w = 0; w < 2; w++) begin
        wd_ph[w] <= WD_HOLD;
        wd_cnt[w] <= '0;
      end
      wd_exp <= '0;
      wd_ev <= '0;
    end else begin
      wd_ev <= '0;
      for (int w = 0; w < 2; w++) begin
        if (rst_cond) begin
          wd_ph[w] <= WD_HOLD;
          wd_cnt[w] <= '0;
          wd_exp[w] <= 1'b0;
        end else begin
          case (wd_ph[w])
            // startup delay before the normal timeout
            WD_HOLD: begin
              wd_ph[w] <= WD_START;
              wd_cnt[w] <= '0;
            end
            WD_START: begin
              if (kick[w] || (tick_ms && wd_cnt[w] + 16'h1 >= cfg[`SSS_CFG_WDT + 5'(w)][31:16])) begin
                wd_ph[w] <= WD_RUN;
                wd_cnt[w] <= '0;
              end else if (tick_ms) begin
                wd_cnt[w] <= wd_cnt[w] + 16'h1;
              end
            end
            WD_RUN: begin
              if (kick[w]) begin
                wd_cnt[w] <= '0;
              end else if (tick_ms) begin
                // Zero timeout disables the watchdog
                if (cfg[`SSS_CFG_WDT + 5'(w)][15:0] != 16'h0 &&
                    wd_cnt[w] + 16'h1 >= cfg[`SSS_CFG_WDT + 5'(w)][15:0]) begin
                  wd_cnt[w] <= '0;
                  wd_exp[w] <= 1'b1;
                  wd_ev[w] <= 1'b1;
                end else begin
                  wd_cnt[w] <= wd_cnt[w] + 16'h1;
                end
              end
            end
            default: wd_ph[w] <= WD_HOLD;
          endcase
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ad_st <= AD_START;
      adc_channel <= '0;
      adc_start <= 1'b0;
      adc_sweep <= 1'b0;
      for (int c = 0; c < 8; c++) begin
        adc_res[c] <= '0;
      end
    end else begin
      adc_sweep <= 1'b0;
      case (ad_st)
        AD_START: begin
          adc_start <= 1'b1;
          ad_st <= AD_WAIT;
        end
        AD_WAIT: begin
          adc_start <= 1'b0;
          if (adc_done) begin
            adc_res[adc_channel] <= adc_data;
            adc_channel <= adc_channel + 3'h1;
            adc_sweep <= adc_channel == 3'h7;
            ad_st <= AD_START;
          end
        end
        default: ad_st <= AD_START;
      endcase
    end
  end

  // AHB-Lite slave: zero wait states, read data latched at the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign acc = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
    end else begin
      wr_pend <= acc && hwrite;
      if (acc) begin
        wr_addr <= haddr[11:0];
      end
      if (acc && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // results and user area readable at any time
  always_comb begin
    rd_data = 32'h0;
    if (is_cfg(haddr[11:0])) begin
      rd_data = cfg[haddr[6:2]];
    end else if (is_user(haddr[11:0])) begin
      rd_data = user_mem[haddr[8:2]];
    end else if (is_adc(haddr[11:0])) begin
      rd_data = {22'h0, adc_res[haddr[4:2]]};
    end else begin
      case (haddr[11:0])
        `SSS_ADDR_CTRL: rd_data = {30'h0, nv_st == NV_LOAD, nv_st == NV_SAVE};
        `SSS_ADDR_STAT: rd_data = {12'h0, wd_exp, margin, mr, eng, out_state};
        `SSS_ADDR_IRQ: rd_data = {26'h0, irq_stat};
        `SSS_ADDR_MASK: rd_data = {26'h0, irq_mask};
        default: rd_data = 32'h0;
      endcase
    end
  end

  // bus writes land directly in the live registers; reload has priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < 25; k++) begin
        cfg[k] <= cfg_default(5'(k));
      end
    // reload from stored image, defaults when none is stored
    end else if (nv_st == NV_LOAD) begin
      cfg[nv_idx] <= nv_valid ? nv_rd : cfg_default(nv_idx);
    // threshold codes live in the same storage
    end else if (wr_pend && is_cfg(wr_addr)) begin
      cfg[wr_addr[6:2]] <= hwdata;
    end
  end

  // hardware reset starts a reload; software reboot does the same
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nv_st <= NV_LOAD;
      nv_idx <= '0;
      nv_done <= 1'b0;
    end else begin
      nv_done <= 1'b0;
      case (nv_st)
        NV_IDLE: begin
          nv_idx <= '0;
          if (wr_pend && wr_addr == `SSS_ADDR_CTRL && hwdata[`SSS_CTRL_REBOOT]) begin
            nv_st <= NV_LOAD;
          end else if (wr_pend && wr_addr == `SSS_ADDR_CTRL && hwdata[`SSS_CTRL_SAVE]) begin
            nv_st <= NV_SAVE;
          end
        end
        NV_SAVE, NV_LOAD: begin
          if (nv_idx == `SSS_CFG_LAST) begin
            nv_st <= NV_IDLE;
            nv_done <= 1'b1;
          end else begin
            nv_idx <= nv_idx + 5'h1;
          end
        end
        default: nv_st <= NV_IDLE;
      endcase
    end
  end

  // Storage arrays model nonvolatile cells, so hresetn does not touch them
  always_ff @(posedge hclk) begin
    if (nv_st == NV_SAVE) begin
      nv_mem[nv_idx] <= cfg[nv_idx];
    end
    if (nv_erase) begin
      nv_valid <= 1'b0;
    end else if (nv_st == NV_SAVE && nv_idx == `SSS_CFG_LAST) begin
      nv_valid <= 1'b1;
    end
    if (wr_pend && is_user(wr_addr)) begin
      user_mem[wr_addr[8:2]] <= hwdata;
    end
  end
  assign nv_rd = nv_mem[nv_idx];

  // Sticky events; a new event in the clearing read's cycle survives
  assign ev = {nv_done, margin & ~margin_q, mr & ~mr_q, adc_sweep, wd_ev};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      // Start high: the pin sync holds manual reset asserted after reset, which is no new press
      mr_q <= 1'b1;
      margin_q <= 1'b1;
    end else begin
      mr_q <= mr;
      margin_q <= margin;
      irq_stat <= ((acc && !hwrite && haddr[11:0] == `SSS_ADDR_IRQ) ? 6'h0 : irq_stat) | ev;
      if (wr_pend && wr_addr == `SSS_ADDR_MASK) begin
        irq_mask <= hwdata[5:0];
      end
    end
  end
  assign irq = |(irq_stat & irq_mask);

  AST_MR_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
    mr |=> out_state == 8'hff) else $error("manual reset did not assert all outputs");
  AST_MR_OVER_MARGIN: assert property (@(posedge hclk) disable iff (!hresetn)
    (mr && margin && !force_mode) ##1 mr |=> out_state == 8'hff) else $error("margin overrode manual reset");
  AST_MARGIN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (margin && !mr && !force_mode) |=> out_state == $past(out_state)) else $error("outputs moved during hold");
  AST_MARGIN_FORCE: assert property (@(posedge hclk) disable iff (!hresetn)
    (margin && !mr && force_mode) |=> out_state == $past(preset_vec)) else $error("preset not applied");
  AST_PIN_POL: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 sequenced_outputs == ~($past(out_state) ^ $past(act_vec))) else $error("pin level wrong");
  AST_PLA_HIT: assert property (@(posedge hclk) disable iff (!hresetn)
    pla_hit != 8'h0 |=> (eng & $past(pla_hit)) == $past(pla_hit)) else $error("term did not assert output");
  AST_DELAY_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng[0] && dcnt[0] < cfg[`SSS_CFG_DELAY][15:0]) |=> eng[0]) else $error("output released early");
  AST_WDT_START: assert property (@(posedge hclk) disable iff (!hresetn)
    (wd_ph[0] == WD_HOLD && !rst_cond) |=> wd_ph[0] == WD_START) else $error("startup phase skipped");
  AST_ADC_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
    (ad_st == AD_WAIT && adc_done) |=> adc_res[$past(adc_channel)] == $past(adc_data)) else $error("result lost");
  AST_CFG_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && is_cfg(wr_addr) && nv_st != NV_LOAD) |=> cfg[$past(wr_addr[6:2])] == $past(hwdata))
    else $error("config write not applied");
  AST_NV_LOAD: assert property (@(posedge hclk) disable iff (!hresetn)
    (nv_st == NV_LOAD && nv_valid) |=> cfg[$past(nv_idx)] == $past(nv_rd)) else $error("reload word wrong");
endmodule
`default_nettype wire

// ### verif/sss_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module sss_adc_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic adc_start, // Conversion request
  input wire logic [2:0] adc_channel, // Channel to convert
  input wire logic [9:0] base, // Result seed from bench
  output logic adc_done, // Result valid pulse
  output logic [9:0] adc_data // Result
);
  logic busy;
  logic [2:0] ch;
  int wait_cyc;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      ch <= 3'h0;
      wait_cyc <= 0;
      adc_done <= 1'b0;
      adc_data <= 10'h0;
    end else begin
      adc_done <= 1'b0;
      // Data only means something with done, so scramble it otherwise
      adc_data <= ~adc_data;
      if (adc_start) begin
        busy <= 1'b1;
        ch <= adc_channel;
        wait_cyc <= $urandom_range(5, 0);
      end else if (busy && wait_cyc > 0) begin
        wait_cyc <= wait_cyc - 1;
      end else if (busy) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_data <= base + 10'(ch);
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import sss_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, mr, mg, nv_erase, adc_start, adc_done, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans, wdt_kick;
  logic [2:0] hsize, adc_channel;
  logic [5:0] mon_a, mon_b;
  logic [3:0] gpi;
  logic [9:0] adc_data, adc_base;
  logic [7:0] pins;
  sss_thr_t [5:0] thr_cfg;
  int err_total, tests_run, t0, k, b, w, n;
  int cyc = 0;

  sss_top #(.TICK_CYC(2), .MS_TICKS(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mon_above_a(mon_a), .mon_above_b(mon_b),
    .general_purpose_inputs(gpi), .manual_reset_in(mr), .margin_in(mg), .wdt_kick(wdt_kick),
    .thr_cfg(thr_cfg), .adc_channel(adc_channel), .adc_start(adc_start), .adc_done(adc_done),
    .adc_data(adc_data), .nv_erase(nv_erase), .sequenced_outputs(pins), .irq(irq));
  sss_adc_model adc (.hclk(hclk), .hresetn(hresetn), .adc_start(adc_start), .adc_channel(adc_channel),
    .base(adc_base), .adc_done(adc_done), .adc_data(adc_data));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= cyc + 1;

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr_en;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic tk(input int c);
    repeat (c) @(posedge hclk);
  endtask
  // Control bits clear when the 25-cycle copy is over
  task automatic poll(input int bn);
    do bus(1'b0, 12'h080, 32'h0); while (rd[bn] !== 1'b0);
  endtask
  function automatic logic pin(input logic asrt, input logic ah);
    return asrt ~^ ah;
  endfunction
  function automatic logic [31:0] ocfg(input logic pre, input logic ah, input int src);
    return {4'h0, pre, ah, 26'(1) << src};
  endfunction
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    hresetn = 1'b0;
    nv_erase = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    mon_a = 6'h3f;
    mon_b = 6'h3f;
    gpi = 4'h0;
    mr = 1'b1;
    mg = 1'b0;
    wdt_kick = 2'b00;
    adc_base = 10'h155;
    void'($urandom(32'h2ee4));
    tk(16);
    hresetn <= 1'b1;
    nv_erase <= 1'b0;
    poll(1);
    rdc("out cfg reset", 12'h000, 32'h3f);
    rdc("misc reset", 12'h058, 32'h4f);
    wr(12'h0c0, 32'hffffffff);
    rdc("unmapped", 12'h0c0, 32'h0);
    chk("bus response", hresp, 1'b0);
    chk("irq idle", irq, 1'b0);
    for (k = 0; k < 8; k++) wr(12'(32 + 4 * k), 32'h0);
    // Random source, output, polarities
    for (n = 0; n < 12; n++) begin
      k = $urandom % 8;
      b = $urandom % 10;
      if (b > 5) b = b + 6;
      v = $urandom;
      wr(12'h058, {25'h0, 3'b100, v[3:0]});
      wr(12'(4 * k), ocfg(1'b0, v[4], b));
      for (w = 0; w < 2; w++) begin
        if (b < 6) mon_a <= ~(6'(w) << b);
        else gpi <= (w != 0) ? v[3:0] : ~v[3:0];
        tk(12);
        chk("logic pin", pins[k], pin(1'(w), v[4]));
      end
      mon_a <= 6'h3f;
    end
    wr(12'h058, 32'h4f);
    gpi <= 4'h0;
    wr(12'h000, ocfg(1'b0, 1'b1, 0));
    wr(12'h020, 32'h6);
    wr(12'h004, ocfg(1'b0, 1'b1, 16) | ocfg(1'b0, 1'b1, 13));
    mon_a <= 6'h3e;
    tk(12);
    chk("chained pins", pins[1:0], 2'b11);
    mon_a <= 6'h3f;
    t0 = cyc;
    while (pins[0] !== 1'b0 && cyc - t0 < 100) @(posedge hclk);
    chk("release delay", (cyc - t0 >= 12) && (cyc - t0 <= 24), 1'b1);
    tk(4);
    chk("follower released", pins[1], 1'b0);
    gpi <= 4'h2;
    tk(12);
    chk("mixed term", pins[1], 1'b1);
    gpi <= 4'h0;
    wr(12'h010, ocfg(1'b1, 1'b1, 14));
    wr(12'h030, 32'h0);
    wr(12'h08c, 32'h8);
    mg <= 1'b1;
    tk(12);
    gpi <= 4'h4;
    tk(12);
    chk("margin hold", pins[4], 1'b0);
    mr <= 1'b0;
    tk(12);
    bus(1'b0, 12'h084, 32'h0);
    chk("mr state", rd[7:0], 8'hff);
    chk("irq raised", irq, 1'b1);
    bus(1'b0, 12'h088, 32'h0);
    chk("irq mr bit", rd[3], 1'b1);
    mr <= 1'b1;
    bus(1'b0, 12'h088, 32'h0);
    chk("irq read clear", rd[3], 1'b0);
    tk(2);
    chk("irq low", irq, 1'b0);
    mg <= 1'b0;
    tk(12);
    chk("hold ended", pins[4], 1'b1);
    wr(12'h058, 32'h5f);
    gpi <= 4'h0;
    tk(12);
    mg <= 1'b1;
    tk(12);
    chk("margin force", pins[4], 1'b1);
    wr(12'h010, ocfg(1'b0, 1'b1, 14));
    tk(4);
    chk("preset live", pins[4], 1'b0);
    mg <= 1'b0;
    wr(12'h058, 32'h4f);
    // Output 0 held asserted keeps the watchdogs in their reset condition
    wr(12'h020, 32'h0);
    mon_a <= 6'h3e;
    wr(12'h05c, {16'd10, 16'd2});
    wr(12'h060, 32'h0);
    tk(12);
    mon_a <= 6'h3f;
    while (pins[0] !== 1'b0) @(posedge hclk);
    t0 = cyc;
    do bus(1'b0, 12'h084, 32'h0); while (rd[18] !== 1'b1 && cyc - t0 < 200);
    chk("startup then timeout", (cyc - t0 >= 36) && (cyc - t0 <= 64), 1'b1);
    chk("second wdt off", rd[19], 1'b0);
    mon_a <= 6'h3e;
    tk(12);
    bus(1'b0, 12'h084, 32'h0);
    chk("expiry cleared", rd[18], 1'b0);
    mon_a <= 6'h3f;
    // Two sweep-done events, so one full sweep saw the new seed
    adc_base <= 10'($urandom);
    bus(1'b0, 12'h088, 32'h0);
    do bus(1'b0, 12'h088, 32'h0); while (rd[2] !== 1'b1);
    do bus(1'b0, 12'h088, 32'h0); while (rd[2] !== 1'b1);
    for (k = 0; k < 8; k++) rdc("adc result", 12'(160 + 4 * k), {22'h0, adc_base + 10'(k)});
    for (k = 0; k < 6; k++) begin
      v = $urandom & 32'h003fffff;
      wr(12'(64 + 4 * k), v);
      // The write lands on the edge the task returns at, so look one cycle later
      tk(1);
      chk("thr cfg", thr_cfg[k], v);
    end
    k = $urandom % 6;
    wr(12'h008, ocfg(1'b0, 1'b1, 6 + k));
    wr(12'h028, 32'h0);
    for (w = 0; w < 2; w++) begin
      for (b = 0; b < 2; b++) begin
        wr(12'(64 + 4 * k), {10'h0, 1'(w), 1'b0, 20'h20100});
        mon_b <= (b != 0) ? 6'h3f : ~(6'h1 << k);
        tk(12);
        chk("window fault", pins[2], 1'(w == b));
      end
    end
    mon_b <= 6'h3f;
    for (n = 0; n < 3; n++) begin
      k = (n == 0) ? 0 : (n == 1) ? 127 : $urandom % 128;
      v = $urandom;
      wr(12'(2048 + 4 * k), v);
      rdc("user word", 12'(2048 + 4 * k), v);
    end
    v = $urandom & 32'h0fffffff;
    wr(12'h00c, v);
    wr(12'h080, 32'h1);
    poll(0);
    wr(12'h00c, 32'h0);
    wr(12'h080, 32'h2);
    poll(1);
    rdc("soft reload", 12'h00c, v);
    hresetn <= 1'b0;
    tk(16);
    hresetn <= 1'b1;
    poll(1);
    rdc("hard reload", 12'h00c, v);
    finish_test();
  end
endmodule
`default_nettype wire
